// >>> logic/mfs_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "mfs_cfg.svh"

module mfs_core (
  input  wire logic                          ref_clk_i,           // System clock.
  input  wire logic                          srst_i,              // Synchronous reset.
  input  wire logic                          ce_i,                // Freezes all state when low.
  input  wire logic                          osc_sel_slow_i,      // Selects the slow oscillator tick.
  input  wire logic                          fast_internal_osc_i, // Fast oscillator tick.
  input  wire logic                          slow_internal_osc_i, // Slow oscillator tick.
  input  wire mfs_pkg::mfs_word_t            pmem_data_i,         // Word at pmem_addr_o.
  output mfs_pkg::mfs_pc_t                   pmem_addr_o,         // Program counter.
  input  wire mfs_pkg::mfs_byte_t            dmem_rdata_i,        // Byte at dmem_addr_o.
  output mfs_pkg::mfs_daddr_t                dmem_addr_o,         // Effective data address.
  output mfs_pkg::mfs_byte_t                 dmem_wdata_o,        // Write data.
  output logic                               dmem_we_o,           // Write strobe.
  input  wire logic                          irq_req_i,           // Enabled interrupt request.
  output logic                               irq_ack_o,           // Acknowledge pulse.
  output logic [`MFS_PHASE_COUNT-1:0]        instruction_phase_clocks_o,
  output mfs_pkg::mfs_byte_t                 acc_o,               // Accumulator.
  output mfs_pkg::mfs_byte_t                 status_o             // Status flags.
);
  import mfs_pkg::*;

  mfs_phase_e phase;                       // Current phase.
  mfs_pc_t    pc;                          // Program counter.
  mfs_word_t  fetch_ir;                    // Prefetched word.
  mfs_word_t  exec_ir;                     // Word in execution.
  logic       flush;                       // Next execute slot is a dummy.
  logic       ext_hold;                    // First half of an extended instruction.
  logic       skip_q;                      // Skip decided in phase three.
  logic       pg_jmp_q;                    // Low byte written in phase three.
  mfs_byte_t  pg_addr;                     // Value written to the low byte.
  mfs_byte_t  acc;                         // Accumulator.
  mfs_byte_t  status;                      // Flags.
  mfs_byte_t  ind_ptr;                     // Indirect pointer.
  mfs_pc_t    stack_mem [0:7];             // Return stack storage.
  logic [2:0] sp;                          // Next free slot.
  logic [3:0] stack_cnt;                   // Levels in use.
  logic       irq_pend;                    // Latched request.
  logic       irq_en;                      // Cleared while servicing.
  logic       step;                        // Phase advance.
  logic       end_t1;
  logic       end_t2;
  logic       end_t3;
  logic       end_t4;
  mfs_op_e    op;                          // Executing operation.
  mfs_byte_t  sfr_rd;                      // Internal register read value.
  mfs_byte_t  operand;                     // Phase three operand.
  mfs_alu_s   alu;                         // ALU outcome.
  logic       writes_acc;
  logic       writes_mem;
  logic       flags_upd;
  logic       status_wr;                   // Destination is the status register.
  logic       is_branch;
  logic       do_call;
  logic       do_ret;
  logic       do_ack;
  mfs_pc_t    stack_top;
  mfs_pc_t    ret_addr;

  // True for operations that touch data memory.
  function automatic logic is_data(input mfs_op_e o);
    return (o != op_nop) && (o < op_jump);
  endfunction : is_data

  // True for register-to-register ALU work with a selectable destination.
  function automatic logic is_alu(input mfs_op_e o);
    return (o >= op_add) && (o <= op_dec);
  endfunction : is_alu

  // Addresses up to and including the last special register in bank 0 stay inside the core.
  function automatic logic is_sfr(input mfs_daddr_t a);
    return !a[8] && (a[7:0] <= `MFS_SFR_LAST);
  endfunction : is_sfr

  // The indirect data slot is replaced by the pointer, so special registers are
  // reachable both ways. [RULE19]
  function automatic mfs_daddr_t eff_addr(input mfs_word_t ir, input mfs_byte_t ptr);
    mfs_daddr_t a;
    a = {ir[`MFS_IR_EXT], ir[7:0]};
    if (a == {1'b0, `MFS_SFR_IND_DATA}) begin
      a = {1'b0, ptr};
    end
    return a;
  endfunction : eff_addr

  // Eight-bit ALU; carry means no borrow on subtract. [RULE16]
  function automatic mfs_alu_s alu_f(input mfs_op_e o, input mfs_byte_t a, input mfs_byte_t m,
                                     input logic cin);
    mfs_alu_s   r;
    logic [8:0] w;
    logic [4:0] n;
    r = '{res: m, c: cin, ac: 1'b0, ov: 1'b0};
    w = '0;
    n = '0;
    case (o)
      op_add: begin
        w = {1'b0, a} + {1'b0, m};
        n = {1'b0, a[3:0]} + {1'b0, m[3:0]};
        r.res = w[7:0];
        r.c = w[8];
        r.ac = n[4];
        r.ov = (a[7] == m[7]) && (w[7] != a[7]);
      end
      op_sub: begin
        w = {1'b0, a} - {1'b0, m};
        n = {1'b0, a[3:0]} - {1'b0, m[3:0]};
        r.res = w[7:0];
        r.c = !w[8];
        r.ac = !n[4];
        r.ov = (a[7] != m[7]) && (w[7] != a[7]);
      end
      op_and:    r.res = a & m;
      op_or:     r.res = a | m;
      op_xor:    r.res = a ^ m;
      op_rotate: r.res = {m[0], m[7:1]};
      op_inc:    r.res = m + 8'h01;
      op_dec:    r.res = m - 8'h01;
      op_store:  r.res = a;
      default:   r.res = m;
    endcase
    return r;
  endfunction : alu_f

  // The selected oscillator tick drives the phase generator. [RULE20]
  assign step   = ce_i && (osc_sel_slow_i ? slow_internal_osc_i : fast_internal_osc_i);
  assign end_t1 = step && (phase == mfs_t1);
  assign end_t2 = step && (phase == mfs_t2);
  assign end_t3 = step && (phase == mfs_t3) && !ext_hold;
  assign end_t4 = step && (phase == mfs_t4) && !ext_hold;
  assign op     = mfs_op_e'(exec_ir[`MFS_IR_OP_HI:`MFS_IR_OP_LO]);

  // Only the low byte of the counter is visible as a register. [RULE9]
  always_comb begin
    case (dmem_addr_o[7:0])
      `MFS_SFR_PC_LOW:  sfr_rd = pc[7:0];
      `MFS_SFR_ACC:     sfr_rd = acc;
      `MFS_SFR_STATUS:  sfr_rd = status;
      `MFS_SFR_IND_PTR: sfr_rd = ind_ptr;
      default:          sfr_rd = 8'h00;
    endcase
  end

  // Operand, result and destination decode for phase three. [RULE17]
  assign operand    = is_sfr(dmem_addr_o) ? sfr_rd : dmem_rdata_i;
  assign alu        = alu_f(op, acc, operand, status[`MFS_ST_C]);
  assign writes_acc = (op == op_load) || (is_alu(op) && !exec_ir[`MFS_IR_DEST]);
  assign writes_mem = (op == op_store) || (is_alu(op) && exec_ir[`MFS_IR_DEST]);
  assign flags_upd  = is_alu(op);
  assign status_wr  = writes_mem && is_sfr(dmem_addr_o) && (dmem_addr_o[7:0] == `MFS_SFR_STATUS);

  // Control decisions taken at the end of phase four.
  assign is_branch = (op == op_jump) || (op == op_call);
  assign do_call   = end_t4 && (op == op_call);
  assign do_ret    = end_t4 && ((op == op_ret) || (op == op_ret_int));
  // A full stack holds the request pending instead of acknowledging. [RULE14]
  assign do_ack    = end_t4 && irq_pend && irq_en && (stack_cnt != `MFS_STACK_DEPTH) && !is_branch
                     && !do_ret && !skip_q && !pg_jmp_q;
  assign stack_top = stack_mem[sp - 3'h1];
  // The prefetched word is where execution resumes.
  assign ret_addr  = pc - 12'h001;

  // Phase generator: a one-hot ring of four phases per instruction cycle. [RULE1]
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      phase <= mfs_t1;
      instruction_phase_clocks_o <= 4'h1;
    end else if (step) begin
      unique case (phase)
        mfs_t1: phase <= mfs_t2;
        mfs_t2: phase <= mfs_t3;
        mfs_t3: phase <= mfs_t4;
        mfs_t4: phase <= mfs_t1;
      endcase
      instruction_phase_clocks_o <= {instruction_phase_clocks_o[2:0], instruction_phase_clocks_o[3]};
    end
  end

  // Fetch pipeline and program counter.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pc <= `MFS_PC_RESET;                                // [RULE21] [RULE8]
      fetch_ir <= '0;
      exec_ir <= '0;
      flush <= 1'b1;
      ext_hold <= 1'b0;
      skip_q <= 1'b0;
      pg_jmp_q <= 1'b0;
      pg_addr <= 8'h00;
    end else if (end_t1) begin
      if (ext_hold) begin
        // Second cycle of an extended instruction; nothing new is fetched. [RULE4]
        ext_hold <= 1'b0;
      end else begin
        // The prefetched word moves to execute while the next is fetched. [RULE3]
        exec_ir <= flush ? '0 : fetch_ir;
        ext_hold <= !flush && fetch_ir[`MFS_IR_EXT]
                    && is_data(mfs_op_e'(fetch_ir[`MFS_IR_OP_HI:`MFS_IR_OP_LO])); // [RULE4]
        fetch_ir <= pmem_data_i;                         // [RULE2]
        pc <= pc + 12'h001;                              // [RULE2] [RULE7]
        flush <= 1'b0;
      end
    end else if (end_t3) begin
      // Zero test rides on the ALU pass-through result.
      skip_q <= (op == op_skip_zero) && (alu.res == 8'h00);
      pg_jmp_q <= writes_mem && is_sfr(dmem_addr_o) && (dmem_addr_o[7:0] == `MFS_SFR_PC_LOW);
      pg_addr <= alu.res;
    end else if (end_t4) begin
      skip_q <= 1'b0;
      pg_jmp_q <= 1'b0;
      if (is_branch) begin
        // Target loaded; the prefetched word is thrown away. [RULE5] [RULE8]
        pc <= exec_ir[11:0];
        flush <= 1'b1;
      end else if (do_ret) begin
        pc <= stack_top;                                 // [RULE12]
        flush <= 1'b1;
      end else if (pg_jmp_q) begin
        // Jump stays in the current page and costs a refetch. [RULE10]
        pc <= {pc[11:8], pg_addr};
        flush <= 1'b1;
      end else if (skip_q) begin
        flush <= 1'b1;                                   // [RULE6]
      end else if (do_ack) begin
        pc <= `MFS_IRQ_VECTOR;                           // [RULE8]
        flush <= 1'b1;
      end
    end
  end

  // Return stack, outside data and program space. A push on a full stack wraps
  // over the oldest entry, which is lost. [RULE11] [RULE15]
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sp <= 3'h0;                                        // [RULE13]
      stack_cnt <= 4'h0;
    end else if (do_call || do_ack) begin
      stack_mem[sp] <= ret_addr;                         // [RULE12]
      sp <= sp + 3'h1;
      if (stack_cnt != `MFS_STACK_DEPTH) begin
        stack_cnt <= stack_cnt + 4'h1;
      end
    end else if (do_ret && (stack_cnt != 4'h0)) begin
      // Popping an empty stack leaves the pointer alone.
      sp <= sp - 3'h1;
      stack_cnt <= stack_cnt - 4'h1;
    end
  end

  // Data path: address in phase two, operate and write back in phase three.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      acc <= `MFS_ACC_RESET;
      status <= `MFS_STATUS_RESET;
      ind_ptr <= 8'h00;
      dmem_addr_o <= '0;
      dmem_wdata_o <= 8'h00;
      dmem_we_o <= 1'b0;
    end else if (ce_i) begin
      dmem_we_o <= 1'b0;
      if (end_t2) begin
        dmem_addr_o <= eff_addr(exec_ir, ind_ptr);       // [RULE19]
      end
      if (end_t3 && is_data(op)) begin
        if (writes_acc) begin
          acc <= alu.res;                                // [RULE17]
        end
        if (writes_mem && is_sfr(dmem_addr_o)) begin
          // Internal registers take the result without a bus write.
          case (dmem_addr_o[7:0])
            `MFS_SFR_ACC:     acc <= alu.res;
            `MFS_SFR_STATUS:  status <= alu.res;
            `MFS_SFR_IND_PTR: ind_ptr <= alu.res;
            default:          ;
          endcase
        end else if (writes_mem) begin
          dmem_we_o <= 1'b1;                             // [RULE17]
          dmem_wdata_o <= alu.res;
        end
        // A direct write to the status register beats the flag update.
        if (flags_upd && !status_wr) begin
          status[`MFS_ST_Z] <= (alu.res == 8'h00);       // [RULE18] [RULE22]
          status[`MFS_ST_C] <= alu.c;
          status[`MFS_ST_AC] <= alu.ac;
          status[`MFS_ST_OV] <= alu.ov;
        end
      end
    end
  end

  // Interrupt latch; a new request in the acknowledge cycle is kept.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_pend <= 1'b0;
      irq_en <= 1'b1;
      irq_ack_o <= 1'b0;
    end else if (ce_i) begin
      irq_pend <= (irq_pend && !do_ack) || irq_req_i;   // [RULE14]
      irq_ack_o <= do_ack;
      if (do_ack) begin
        irq_en <= 1'b0;
      end else if (end_t4 && (op == op_ret_int)) begin
        irq_en <= 1'b1;
      end
    end
  end

  assign pmem_addr_o = pc;
  assign acc_o = acc;
  assign status_o = status;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence t4_branch_s;
    end_t4 && is_branch;
  endsequence
  sequence t4_call_s;
    end_t4 && (op == op_call);
  endsequence
  sequence t4_pop_s;
    do_ret && (stack_cnt != 4'h0);
  endsequence

  phase_onehot_a: assert property ($onehot(instruction_phase_clocks_o)) // [RULE1]
    else $error("phase outputs not one-hot");
  phase_ring_a: assert property (step |=> instruction_phase_clocks_o == // [RULE1]
      {$past(instruction_phase_clocks_o[2:0]), $past(instruction_phase_clocks_o[3])})
    else $error("phase ring did not rotate");
  fetch_count_a: assert property (end_t1 && !ext_hold |=> pc == $past(pc) + 12'h001) // [RULE2]
    else $error("counter did not advance on fetch");
  fetch_overlap_a: assert property (end_t1 && !ext_hold && !flush |=> // [RULE3]
      exec_ir == $past(fetch_ir) && fetch_ir == $past(pmem_data_i))
    else $error("fetch and execute did not overlap");
  ext_stretch_a: assert property (step && phase == mfs_t1 && ext_hold |=> pc == $past(pc) && !ext_hold) // [RULE4]
    else $error("extended instruction not stretched");
  branch_target_a: assert property (t4_branch_s |=> flush && pc == $past(exec_ir[11:0])) // [RULE5]
    else $error("branch did not load target and flush");
  skip_dummy_a: assert property (end_t4 && skip_q && !is_branch && !do_ret |=> flush) // [RULE6]
    else $error("taken skip did not insert dummy");
  page_jump_a: assert property (end_t4 && pg_jmp_q && !is_branch && !do_ret |=> // [RULE10]
      pc[11:8] == $past(pc[11:8]) && pc[7:0] == $past(pg_addr) && flush)
    else $error("low byte jump left the page");
  call_push_a: assert property (t4_call_s |=> stack_cnt == // [RULE15]
      (($past(stack_cnt) == 4'h8) ? 4'h8 : $past(stack_cnt) + 4'h1))
    else $error("call push count wrong");
  ret_pop_a: assert property (t4_pop_s |=> stack_cnt == $past(stack_cnt) - 4'h1 && // [RULE12]
      pc == $past(stack_top))
    else $error("return did not pop");
  full_hold_a: assert property (irq_ack_o |-> $past(stack_cnt) != 4'h8) // [RULE14]
    else $error("acknowledge on full stack");
  reset_start_a: assert property (disable iff (1'b0) srst_i |=> // [RULE21]
      pc == 12'h000 && stack_cnt == 4'h0 && sp == 3'h0)
    else $error("reset state wrong");
  zero_flag_a: assert property (end_t3 && is_data(op) && flags_upd && !status_wr |=> // [RULE18]
      status[`MFS_ST_Z] == ($past(alu.res) == 8'h00))
    else $error("zero flag not updated");

endmodule : mfs_core
`default_nettype wire

// >>> common/mfs_cfg.svh
// Functional notes
// RULE1 - Four non-overlapping phases form one instruction cycle.
// RULE2 - Fetch and count up in first phase.
// RULE3 - Next fetch overlaps current instruction execution.
// RULE4 - Standard one cycle, extended two, branches more.
// RULE5 - Jump or call flushes the prefetched instruction.
// RULE6 - Taken skip discards prefetch, runs dummy cycle.
// RULE7 - Program counter advances by one otherwise.
// RULE8 - Jumps, calls, interrupts, reset load target directly.
// RULE9 - Twelve-bit counter; only low byte software visible.
// RULE10 - Low byte write jumps in page, dummy.
// RULE11 - Eight-level stack, hidden from software entirely.
// RULE12 - Call or acknowledge pushes; returns pop.
// RULE13 - Reset points stack pointer at stack top.
// RULE14 - Full stack latches request, withholds acknowledge.
// RULE15 - Call on full stack loses oldest entry.
// RULE16 - Eight-bit ALU serves arithmetic, logic, rotate, tests.
// RULE17 - Data moves through accumulator; result to destination.
// RULE18 - ALU outcomes update the status register.
// RULE19 - Special registers sit in data space, indirectly reachable.
// RULE20 - Phase source selectable: fast or slow oscillator.
// RULE21 - Reset loads address zero and starts there.
// RULE22 - Status bit positions chosen for this block.
`ifndef MFS_CFG_SVH
`define MFS_CFG_SVH

// Special registers in data bank 0.
`define MFS_SFR_IND_DATA 8'h00
`define MFS_SFR_IND_PTR  8'h01
`define MFS_SFR_PC_LOW   8'h02
`define MFS_SFR_ACC      8'h03
`define MFS_SFR_STATUS   8'h04
`define MFS_SFR_LAST     8'h07

// Status flag positions.
`define MFS_ST_C  0
`define MFS_ST_AC 1
`define MFS_ST_Z  2
`define MFS_ST_OV 3

// Instruction word fields.
`define MFS_IR_OP_HI 15
`define MFS_IR_OP_LO 12
`define MFS_IR_EXT   9
`define MFS_IR_DEST  8

// Reset values, interrupt vector and sizes.
`define MFS_PC_RESET     12'h000
`define MFS_IRQ_VECTOR   12'h004
`define MFS_ACC_RESET    8'h00
`define MFS_STATUS_RESET 8'h00
`define MFS_STACK_DEPTH  4'h8
`define MFS_PHASE_COUNT  4

`endif

// >>> common/mfs_pkg.sv
`default_nettype none
package mfs_pkg;

  // Instruction phases, Gray coded along the cycle.
  typedef enum logic [1:0] {
    mfs_t1 = 2'h0,
    mfs_t2 = 2'h1,
    mfs_t3 = 2'h3,
    mfs_t4 = 2'h2
  } mfs_phase_e;

  // Operation classes held in the top nibble of an instruction word.
  typedef enum logic [3:0] {
    op_nop, op_load, op_store, op_add, op_sub, op_and, op_or, op_xor,
    op_rotate, op_inc, op_dec, op_skip_zero, op_jump, op_call, op_ret, op_ret_int
  } mfs_op_e;

  typedef logic [11:0] mfs_pc_t;     // Program address.
  typedef logic [15:0] mfs_word_t;   // Program word.
  typedef logic [7:0]  mfs_byte_t;   // Data byte.
  typedef logic [8:0]  mfs_daddr_t;  // Data address, bank bit on top.

  // ALU outcome.
  typedef struct packed {
    mfs_byte_t res;
    logic      c;
    logic      ac;
    logic      ov;
  } mfs_alu_s;

endpackage : mfs_pkg
`default_nettype wire

// >>> test/mfs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far side of the core: a 4K-word program store and a two-bank data store.
module mfs_mem_model (
  input  wire logic                ref_clk_i,    // System clock.
  input  wire mfs_pkg::mfs_pc_t    pmem_addr_i,  // Fetch address.
  output var  mfs_pkg::mfs_word_t  pmem_data_o,  // Word at the fetch address.
  input  wire mfs_pkg::mfs_daddr_t dmem_addr_i,  // Data address with bank bit.
  input  wire mfs_pkg::mfs_byte_t  dmem_wdata_i, // Write data.
  input  wire logic                dmem_we_i,    // Write strobe.
  output var  mfs_pkg::mfs_byte_t  dmem_rdata_o  // Byte at the data address.
);
  import mfs_pkg::*;

  mfs_word_t pm [0:4095]; // Program words; the bench loads them.
  mfs_byte_t dm [0:511];  // Data bytes; the bench may preset them.

  // Both stores answer at once, since the core samples without a wait state.
  assign pmem_data_o  = pm[pmem_addr_i];
  assign dmem_rdata_o = dm[dmem_addr_i];

  // A plain process is used so that the bench may also poke the store directly.
  always @(posedge ref_clk_i) begin
    if (dmem_we_i) begin
      dm[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule : mfs_mem_model

`default_nettype wire

// >>> test/mcu_core_fetch_execute_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none

module mcu_core_fetch_execute_sequencer_tb;
  import mfs_pkg::*;

  logic       ref_clk, srst, ce, osc_sel_slow, fast_osc, slow_osc, irq_req;
  logic       dmem_we, irq_ack, seen;
  logic [3:0] phase, p;
  mfs_pc_t    pmem_addr;
  mfs_word_t  pmem_data;
  mfs_daddr_t dmem_addr;
  mfs_byte_t  dmem_wdata, dmem_rdata, acc, status;
  int         fail_count, check_count;

  mfs_core dut_u (.ref_clk_i(ref_clk), .srst_i(srst), .ce_i(ce), .osc_sel_slow_i(osc_sel_slow),
    .fast_internal_osc_i(fast_osc), .slow_internal_osc_i(slow_osc), .pmem_data_i(pmem_data),
    .pmem_addr_o(pmem_addr), .dmem_rdata_i(dmem_rdata), .dmem_addr_o(dmem_addr),
    .dmem_wdata_o(dmem_wdata), .dmem_we_o(dmem_we), .irq_req_i(irq_req), .irq_ack_o(irq_ack),
    .instruction_phase_clocks_o(phase), .acc_o(acc), .status_o(status));

  mfs_mem_model mem_u (.ref_clk_i(ref_clk), .pmem_addr_i(pmem_addr), .pmem_data_o(pmem_data),
    .dmem_addr_i(dmem_addr), .dmem_wdata_i(dmem_wdata), .dmem_we_i(dmem_we), .dmem_rdata_o(dmem_rdata));

  // Builds a program word from an operation and its twelve-bit field.
  function automatic mfs_word_t w(input mfs_op_e op, input logic [11:0] f);
    return {op, f};
  endfunction : w

  // Compares a multi-bit value; an unknown bit matches only an unknown expected bit.
  task automatic chk_val(input logic [15:0] act, input logic [15:0] exp, input string what);
    check_count++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, act, exp);
    end
  endtask : chk_val

  // Compares a single flag.
  task automatic chk_flag(input logic act, input logic exp, input string what);
    check_count++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %b expected %b", $time, what, act, exp);
    end
  endtask : chk_flag

  // Waits for a fetch address, bounded so that a stuck sequencer cannot hang the run.
  task automatic wait_pc(input mfs_pc_t a);
    int n;
    n = 0;
    while (pmem_addr !== a && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk_val({4'h0, pmem_addr}, {4'h0, a}, "fetch address not reached");
  endtask : wait_pc

  // Watches for an acknowledge pulse over a bounded number of clocks.
  task automatic wait_ack(input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge ref_clk);
      #1;
      hit = (irq_ack === 1'b1);
    end
  endtask : wait_ack

  // One-clock request pulse; the core has to latch it itself.
  task automatic pulse_irq;
    @(posedge ref_clk);
    irq_req <= 1'b1;
    @(posedge ref_clk);
    irq_req <= 1'b0;
  endtask : pulse_irq

  // Holds reset for six clocks and releases it on a rising edge.
  task automatic do_reset;
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic summarize;
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Free-running 25 MHz system clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Cuts a hang short well beyond the few hundred clocks the tests need.
  initial begin
    #400000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    {srst, ce, osc_sel_slow, fast_osc, slow_osc, irq_req} <= 6'b110100;
    fail_count = 0;
    check_count = 0;
    for (int i = 0; i < 4096; i++) mem_u.pm[i] = 16'h0000;
    for (int i = 0; i < 512; i++) mem_u.dm[i] = 8'h00;
    // Main program: data path, flushes, skip, call, page jump; ISR sits at the vector.
    mem_u.pm[0]  = w(op_load, 12'h020);
    mem_u.pm[1]  = w(op_store, 12'h322);
    mem_u.pm[2]  = w(op_add, 12'h021);
    mem_u.pm[3]  = w(op_jump, 12'h010);
    mem_u.pm[4]  = w(op_inc, 12'h128);
    mem_u.pm[5]  = w(op_ret_int, 12'h000);
    mem_u.pm[16] = w(op_store, 12'h124);
    mem_u.pm[17] = w(op_skip_zero, 12'h024);
    mem_u.pm[18] = w(op_inc, 12'h125);
    mem_u.pm[19] = w(op_call, 12'h030);
    mem_u.pm[20] = w(op_load, 12'h026);
    mem_u.pm[21] = w(op_store, 12'h102);
    mem_u.pm[22] = w(op_inc, 12'h127);
    mem_u.pm[33] = w(op_jump, 12'h020);
    mem_u.pm[48] = w(op_inc, 12'h129);
    mem_u.pm[49] = w(op_ret, 12'h000);
    mem_u.pm[50] = w(op_inc, 12'h127);
    mem_u.dm[9'h020] = 8'h05;
    mem_u.dm[9'h021] = 8'hfb;
    mem_u.dm[9'h024] = 8'haa;
    mem_u.dm[9'h026] = 8'h20;
    mem_u.dm[9'h002] = 8'h5a;
    repeat (5) @(posedge ref_clk);
    #1;
    chk_val({4'h0, pmem_addr}, 16'h0000, "reset address");
    chk_val({12'h0, phase}, 16'h0001, "reset phase");
    chk_val({acc, status}, 16'h0000, "reset acc and status");
    chk_flag(dmem_we | irq_ack, 1'b0, "reset strobes");
    @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_val({4'h0, pmem_addr}, 16'h0001, "count after first phase");
    chk_val({12'h0, phase}, 16'h0002, "second phase");
    // Counter holds through the remaining phases and steps only at the end of the first.
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      #1;
      chk_val({12'h0, phase}, 16'h0001 << ((i + 2) % 4), "phase order");
      chk_val({4'h0, pmem_addr}, 16'h0001, "count held");
    end
    // The slow source with no tick must freeze the phases; one tick steps them once.
    @(posedge ref_clk);
    osc_sel_slow <= 1'b1;
    @(posedge ref_clk);
    #1;
    p = phase;
    repeat (6) @(posedge ref_clk);
    #1;
    chk_val({12'h0, phase}, {12'h0, p}, "frozen phase");
    @(posedge ref_clk);
    slow_osc <= 1'b1;
    @(posedge ref_clk);
    slow_osc <= 1'b0;
    osc_sel_slow <= 1'b0;
    #1;
    chk_val({12'h0, phase}, {12'h0, p[2:0], p[3]}, "slow step");
    wait_pc(12'h010);
    chk_val({acc, status}, 16'h0007, "add result and flags");
    chk_val({8'h0, mem_u.dm[9'h122]}, 16'h0005, "extended store");
    wait_pc(12'h021);
    chk_val({8'h0, mem_u.dm[9'h024]}, 16'h0000, "stored accumulator");
    chk_val({8'h0, mem_u.dm[9'h025]}, 16'h0000, "skipped word ran");
    chk_val({8'h0, mem_u.dm[9'h029]}, 16'h0001, "subroutine result");
    chk_val({8'h0, mem_u.dm[9'h027]}, 16'h0000, "flushed word ran");
    chk_val({8'h0, mem_u.dm[9'h028]}, 16'h0000, "jump prefetch ran");
    chk_val({8'h0, mem_u.dm[9'h002]}, 16'h005a, "internal write reached bus");
    chk_val({8'h0, acc}, 16'h0020, "load result");
    pulse_irq();
    wait_ack(40, seen);
    chk_flag(seen, 1'b1, "interrupt acknowledge");
    chk_val({4'h0, pmem_addr}, 16'h0004, "vector address");
    wait_pc(12'h021);
    chk_val({8'h0, mem_u.dm[9'h028]}, 16'h0001, "service routine");
    // Second program: pointer set through its internal register and one indirect
    // increment, then eight nested calls fill the stack and a pending request must wait.
    mem_u.pm[0] = w(op_load, 12'h02b);
    mem_u.pm[1] = w(op_store, 12'h101);
    mem_u.pm[2] = w(op_inc, 12'h100);
    mem_u.pm[3] = w(op_jump, 12'h040);
    for (int i = 0; i < 8; i++) mem_u.pm[64 + i] = w(op_call, 12'(65 + i));
    mem_u.pm[72] = w(op_skip_zero, 12'h02a);
    mem_u.pm[73] = w(op_jump, 12'h048);
    mem_u.pm[74] = w(op_nop, 12'h000);
    mem_u.pm[75] = w(op_ret, 12'h000);
    mem_u.dm[9'h02a] = 8'h01;
    mem_u.dm[9'h02b] = 8'h2c;
    do_reset();
    wait_pc(12'h049);
    pulse_irq();
    wait_ack(60, seen);
    chk_flag(seen, 1'b0, "acknowledge with full stack");
    mem_u.dm[9'h02a] = 8'h00;
    wait_ack(80, seen);
    chk_flag(seen, 1'b1, "acknowledge after return");
    chk_val({4'h0, pmem_addr}, 16'h0004, "vector after return");
    chk_val({8'h0, mem_u.dm[9'h02c]}, 16'h0001, "indirect increment");
    summarize();
  end
endmodule : mcu_core_fetch_execute_sequencer_tb

`default_nettype wire
